// ---- fast_lock_pkg.sv ----
// ==========================================================
// Shared constants for the fast-lock profile store
// ==========================================================
package fast_lock_pkg;

  // ==========================================================
  // Bus and storage geometry
  // ==========================================================
  localparam int unsigned ADDR_W   = 12;  // APB byte address width
  localparam int unsigned DATA_W   = 32;  // APB data width
  localparam int unsigned BYTE_W   = 8;   // Register and word width
  localparam int unsigned PROF_W   = 3;   // Profile number width
  localparam int unsigned WSEL_W   = 4;   // Word index width
  localparam int unsigned SLOT_W   = PROF_W + WSEL_W;
  localparam int unsigned WORDS    = 16;  // Words per profile
  localparam int unsigned SLOTS    = 128; // Words in the store

  // ==========================================================
  // Register indices and byte addresses (index times four)
  // ==========================================================
  localparam logic [11:0] IDX_SETUP = 12'h25A; // Fast-lock setup
  localparam logic [11:0] IDX_DELAY = 12'h25B; // Init delay
  localparam logic [11:0] IDX_ADDR  = 12'h25C; // Program address
  localparam logic [11:0] IDX_DATA  = 12'h25D; // Program data
  localparam logic [11:0] IDX_READ  = 12'h25E; // Program read data
  localparam logic [11:0] IDX_CTRL  = 12'h25F; // Program control
  localparam logic [11:0] ADR_SETUP = {IDX_SETUP[9:0], 2'b00};
  localparam logic [11:0] ADR_DELAY = {IDX_DELAY[9:0], 2'b00};
  localparam logic [11:0] ADR_ADDR  = {IDX_ADDR[9:0], 2'b00};
  localparam logic [11:0] ADR_DATA  = {IDX_DATA[9:0], 2'b00};
  localparam logic [11:0] ADR_READ  = {IDX_READ[9:0], 2'b00};
  localparam logic [11:0] ADR_CTRL  = {IDX_CTRL[9:0], 2'b00};

  // ==========================================================
  // Field positions and reset values
  // ==========================================================
  localparam int unsigned SETUP_PROF_LSB = 5; // Profile in bits 7:5
  localparam int unsigned SETUP_PIN_BIT  = 1; // Pin select flag
  localparam int unsigned SETUP_EN_BIT   = 0; // Fast-lock enable
  localparam int unsigned CTRL_WR_BIT    = 1; // Program write
  localparam int unsigned CTRL_CLK_BIT   = 0; // Program clock enable
  localparam int unsigned PADDR_HIGH_BIT = 7; // Top of profile nibble
  localparam logic [7:0]  RST_BYTE       = 8'h00;

  // ==========================================================
  // Configuration word indices
  // ==========================================================
  localparam int unsigned W_INT_LO  = 0;
  localparam int unsigned W_INT_HI  = 1;
  localparam int unsigned W_FRAC_0  = 2;
  localparam int unsigned W_FRAC_1  = 3;
  localparam int unsigned W_FRAC_2  = 4;
  localparam int unsigned W_VCO     = 5;
  localparam int unsigned W_TCF_CP  = 6;
  localparam int unsigned W_CP      = 7;
  localparam int unsigned W_R3      = 8;
  localparam int unsigned W_C3      = 9;
  localparam int unsigned W_C1C2    = 10;
  localparam int unsigned W_R1      = 11;
  localparam int unsigned W_DIV     = 12;
  localparam int unsigned W_CAL     = 13;
  localparam int unsigned W_TUNE    = 14;
  localparam int unsigned W_LVL     = 15;

  // ==========================================================
  // Field slices of a configuration word
  // ==========================================================
  function automatic logic [3:0] hi_nib(input logic [7:0] b);
    return b[7:4];
  endfunction
  function automatic logic [3:0] lo_nib(input logic [7:0] b);
    return b[3:0];
  endfunction
  function automatic logic [2:0] bits_6_4(input logic [7:0] b);
    return b[6:4];
  endfunction
  function automatic logic [1:0] bits_7_6(input logic [7:0] b);
    return b[7:6];
  endfunction
  function automatic logic [5:0] bits_5_0(input logic [7:0] b);
    return b[5:0];
  endfunction
  function automatic logic [6:0] bits_7_1(input logic [7:0] b);
    return b[7:1];
  endfunction
  function automatic logic [6:0] bits_6_0(input logic [7:0] b);
    return b[6:0];
  endfunction
  function automatic logic [2:0] bits_2_0(input logic [7:0] b);
    return b[2:0];
  endfunction

endpackage

// ---- profile_if.sv ----
`timescale 1ns/1ps
// ==========================================================
// Link between the register front end and the profile array
// ==========================================================
interface profile_if;
  logic                                   wr_en;     // Commit strobe
  logic [fast_lock_pkg::SLOT_W-1:0]       wr_slot;   // Profile and word
  logic [fast_lock_pkg::BYTE_W-1:0]       wr_data;   // Word to store
  logic [fast_lock_pkg::SLOT_W-1:0]       rd_slot;   // Readback slot
  logic [fast_lock_pkg::BYTE_W-1:0]       rd_data;   // Readback word
  logic [fast_lock_pkg::PROF_W-1:0]       act_prof;  // Active profile
  logic [fast_lock_pkg::WORDS*8-1:0]      act_words; // Active words

  modport ctrl (output wr_en, wr_slot, wr_data, rd_slot, act_prof,
                input rd_data, act_words);
  modport store (input wr_en, wr_slot, wr_data, rd_slot, act_prof,
                 output rd_data, act_words);
endinterface

// ---- profile_array.sv ----
`timescale 1ns/1ps
// ==========================================================
// Eight profiles of sixteen words each
// ==========================================================
module profile_array (
  input  wire logic sys_clk,       // System clock
  input  wire logic rst_b,         // Synchronous reset, active low
  profile_if.store  pif            // Store side of the link
);

  logic [7:0] mem [fast_lock_pkg::SLOTS]; // Word storage

  // Clear on reset, store a committed word otherwise
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < fast_lock_pkg::SLOTS; i++)
        mem[i] <= fast_lock_pkg::RST_BYTE;
    end
    else if (pif.wr_en)
      mem[pif.wr_slot] <= pif.wr_data;
  end

  // Readback of any slot
  assign pif.rd_data = mem[pif.rd_slot];

  // All words of the active profile side by side
  genvar g;
  generate
    for (g = 0; g < fast_lock_pkg::WORDS; g++)
    begin : g_act
      assign pif.act_words[g*8 +: 8] = mem[{pif.act_prof, 4'(g)}];
    end
  endgenerate

endmodule

// ---- wide_bw_timer.sv ----
`timescale 1ns/1ps
// ==========================================================
// Holds the wide-bandwidth phase after a profile switch
// ==========================================================
module wide_bw_timer (
  input  wire logic       sys_clk,  // System clock
  input  wire logic       rst_b,    // Synchronous reset, active low
  input  wire logic       start,    // Profile switch pulse
  input  wire logic [7:0] delay,    // Phase length in cycles
  output logic            active    // Wide-bandwidth phase running
);

  logic [7:0] cnt_r; // Cycles left in the phase

  // Reload on a switch, count down to zero
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      cnt_r <= fast_lock_pkg::RST_BYTE;
    else if (start)
      cnt_r <= delay;
    else if (cnt_r != fast_lock_pkg::RST_BYTE)
      cnt_r <= cnt_r - 8'h01;
  end

  assign active = (cnt_r != fast_lock_pkg::RST_BYTE);

endmodule

// ---- fast_lock_store.sv ----
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module fast_lock_store (
  input  wire logic        sys_clk,                 // 20 MHz clock
  input  wire logic        rst_b,                   // Sync reset, low
  input  wire logic        psel,                    // APB select
  input  wire logic        penable,                 // APB enable
  input  wire logic        pwrite,                  // APB direction
  input  wire logic [11:0] paddr,                   // APB address
  input  wire logic [31:0] pwdata,                  // APB write data
  output logic      [31:0] prdata,                  // APB read data
  output logic             pready,                  // APB ready
  output logic             pslverr,                 // APB error
  output logic             lock_enable,             // Fast-lock on
  output logic             pin_select,              // Pin select flag
  output logic      [2:0]  active_profile,          // Selected profile
  output logic             wide_bw,                 // Initial phase
  output logic      [10:0] synth_int,               // Integer word
  output logic      [22:0] synth_frac,              // Fractional word
  output logic      [2:0]  vco_bias_ref,            // Bias reference
  output logic      [3:0]  varactor,                // Varactor setting
  output logic      [1:0]  bias_tcf,                // Bias tempco
  output logic      [5:0]  init_cp_current,         // Initial pump
  output logic      [5:0]  cp_current,              // Pump current
  output logic      [3:0]  third_res,               // Third resistor
  output logic      [3:0]  initial_third_resistor,  // Its initial value
  output logic      [3:0]  third_cap,               // Third capacitor
  output logic      [3:0]  initial_third_capacitor, // Its initial value
  output logic      [3:0]  first_cap,               // First capacitor
  output logic      [3:0]  second_cap,              // Second capacitor
  output logic      [3:0]  first_res,               // First resistor
  output logic      [3:0]  initial_first_resistor,  // Its initial value
  output logic      [2:0]  varactor_ref_tcf,        // Varactor tempco
  output logic      [3:0]  vco_divider,             // Output divider
  output logic      [3:0]  vco_cal_offset,          // Cal offset
  output logic      [3:0]  varactor_ref,            // Varactor ref
  output logic      [8:0]  force_tune,              // Forced tune
  output logic      [6:0]  level_control_word       // Forced level
);

  // ==========================================================
  // Address decode
  // ==========================================================
  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    return (a == r);
  endfunction

  profile_if pif ();

  logic        setup_ph;   // APB setup cycle
  logic        wr_acc;     // Write taking effect
  logic        sel_setup;  // Setup register addressed
  logic        sel_delay;  // Delay register addressed
  logic        sel_addr;   // Address register addressed
  logic        sel_data;   // Data register addressed
  logic        sel_read;   // Read register addressed
  logic        sel_ctrl;   // Control register addressed
  logic        mapped;     // Any register addressed
  logic        commit;     // Store one word now
  logic        sw_start;   // Profile switch pulse
  logic [7:0]  rd_mux;     // Selected read byte
  logic [7:0]  w [16];     // Words of the active profile

  assign setup_ph  = psel & ~penable;
  assign wr_acc    = psel & penable & pwrite;
  assign sel_setup = hit(paddr, fast_lock_pkg::ADR_SETUP);
  assign sel_delay = hit(paddr, fast_lock_pkg::ADR_DELAY);
  assign sel_addr  = hit(paddr, fast_lock_pkg::ADR_ADDR);
  assign sel_data  = hit(paddr, fast_lock_pkg::ADR_DATA);
  assign sel_read  = hit(paddr, fast_lock_pkg::ADR_READ);
  assign sel_ctrl  = hit(paddr, fast_lock_pkg::ADR_CTRL);
  assign mapped    = sel_setup | sel_delay | sel_addr | sel_data | sel_read | sel_ctrl;

  // ==========================================================
  // Software registers
  // ==========================================================
  logic [7:0]  setup_r;    // Profile, pin select, enable
  logic [7:0]  delay_r;    // Initial phase length
  logic [7:0]  addr_r;     // Program address byte
  logic [7:0]  data_r;     // Program data byte
  logic [7:0]  ctrl_r;     // Program control byte
  logic [31:0] prdata_r;   // Latched read data
  logic        slverr_r;   // Latched error answer

  // Register writes at the access edge
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      setup_r <= fast_lock_pkg::RST_BYTE;
      delay_r <= fast_lock_pkg::RST_BYTE;
      addr_r  <= fast_lock_pkg::RST_BYTE;
      data_r  <= fast_lock_pkg::RST_BYTE;
      ctrl_r  <= fast_lock_pkg::RST_BYTE;
    end
    else if (wr_acc)
    begin
      if (sel_setup)
        setup_r <= pwdata[7:0];
      if (sel_delay)
        delay_r <= pwdata[7:0];
      if (sel_addr)
        addr_r <= pwdata[7:0];
      if (sel_data)
        data_r <= pwdata[7:0];
      if (sel_ctrl)
        ctrl_r <= pwdata[7:0];
    end
  end

  // Read selection
  always_comb
  begin
    if (sel_setup)
      rd_mux = setup_r;
    else if (sel_delay)
      rd_mux = delay_r;
    else if (sel_addr)
      rd_mux = addr_r;
    else if (sel_data)
      rd_mux = data_r;
    else if (sel_read)
      rd_mux = addr_r[fast_lock_pkg::PADDR_HIGH_BIT] ? fast_lock_pkg::RST_BYTE : pif.rd_data;
    else if (sel_ctrl)
      rd_mux = ctrl_r;
    else
      rd_mux = fast_lock_pkg::RST_BYTE;
  end

  // Answer latched in the setup cycle, shown in the access cycle
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      prdata_r <= '0;
      slverr_r <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata_r <= {24'h000000, rd_mux};
      slverr_r <= ~mapped;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = psel & penable;
  assign pslverr = psel & penable & slverr_r;

  // ==========================================================
  // Profile store link
  // ==========================================================
  // Commit only with both control bits set and a profile 0-7
  assign commit = wr_acc & sel_ctrl & pwdata[fast_lock_pkg::CTRL_WR_BIT]
                & pwdata[fast_lock_pkg::CTRL_CLK_BIT]
                & ~addr_r[fast_lock_pkg::PADDR_HIGH_BIT];

  assign pif.wr_en    = commit;
  assign pif.wr_slot  = addr_r[fast_lock_pkg::SLOT_W-1:0];
  assign pif.wr_data  = data_r;
  assign pif.rd_slot  = addr_r[fast_lock_pkg::SLOT_W-1:0];
  assign pif.act_prof = setup_r[7:fast_lock_pkg::SETUP_PROF_LSB];

  profile_array u_array (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .pif     (pif.store)
  );

  // Split the active profile into words
  genvar g;
  generate
    for (g = 0; g < fast_lock_pkg::WORDS; g++)
    begin : g_word
      assign w[g] = pif.act_words[g*8 +: 8];
    end
  endgenerate

  // ==========================================================
  // Setup outputs and initial phase
  // ==========================================================
  assign lock_enable    = setup_r[fast_lock_pkg::SETUP_EN_BIT];
  assign pin_select     = setup_r[fast_lock_pkg::SETUP_PIN_BIT];
  assign active_profile = setup_r[7:fast_lock_pkg::SETUP_PROF_LSB];
  assign sw_start = wr_acc & sel_setup & pwdata[fast_lock_pkg::SETUP_EN_BIT];

  wide_bw_timer u_timer (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .start   (sw_start),
    .delay   (delay_r),
    .active  (wide_bw)
  );

  // ==========================================================
  // Field unpacking of the active profile
  // ==========================================================
  // Fields follow the stored words while fast-lock is enabled
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      synth_int               <= '0;
      synth_frac              <= '0;
      vco_bias_ref            <= '0;
      varactor                <= '0;
      bias_tcf                <= '0;
      init_cp_current         <= '0;
      cp_current              <= '0;
      third_res               <= '0;
      initial_third_resistor  <= '0;
      third_cap               <= '0;
      initial_third_capacitor <= '0;
      first_cap               <= '0;
      second_cap              <= '0;
      first_res               <= '0;
      initial_first_resistor  <= '0;
      varactor_ref_tcf        <= '0;
      vco_divider             <= '0;
      vco_cal_offset          <= '0;
      varactor_ref            <= '0;
      force_tune              <= '0;
      level_control_word      <= '0;
    end
    else if (lock_enable)
    begin
      synth_int <= {fast_lock_pkg::bits_2_0(w[fast_lock_pkg::W_INT_HI]),
                    w[fast_lock_pkg::W_INT_LO]};
      synth_frac <= {fast_lock_pkg::bits_6_0(w[fast_lock_pkg::W_FRAC_2]),
                     w[fast_lock_pkg::W_FRAC_1], w[fast_lock_pkg::W_FRAC_0]};
      vco_bias_ref <= fast_lock_pkg::bits_6_4(w[fast_lock_pkg::W_VCO]);
      varactor <= fast_lock_pkg::lo_nib(w[fast_lock_pkg::W_VCO]);
      bias_tcf <= fast_lock_pkg::bits_7_6(w[fast_lock_pkg::W_TCF_CP]);
      init_cp_current <= fast_lock_pkg::bits_5_0(w[fast_lock_pkg::W_TCF_CP]);
      cp_current <= fast_lock_pkg::bits_5_0(w[fast_lock_pkg::W_CP]);
      third_res <= fast_lock_pkg::hi_nib(w[fast_lock_pkg::W_R3]);
      initial_third_resistor <= fast_lock_pkg::lo_nib(w[fast_lock_pkg::W_R3]);
      third_cap <= fast_lock_pkg::hi_nib(w[fast_lock_pkg::W_C3]);
      initial_third_capacitor <= fast_lock_pkg::lo_nib(w[fast_lock_pkg::W_C3]);
      first_cap <= fast_lock_pkg::hi_nib(w[fast_lock_pkg::W_C1C2]);
      second_cap <= fast_lock_pkg::lo_nib(w[fast_lock_pkg::W_C1C2]);
      first_res <= fast_lock_pkg::hi_nib(w[fast_lock_pkg::W_R1]);
      initial_first_resistor <= fast_lock_pkg::lo_nib(w[fast_lock_pkg::W_R1]);
      varactor_ref_tcf <= fast_lock_pkg::bits_6_4(w[fast_lock_pkg::W_DIV]);
      vco_divider <= fast_lock_pkg::lo_nib(w[fast_lock_pkg::W_DIV]);
      vco_cal_offset <= fast_lock_pkg::hi_nib(w[fast_lock_pkg::W_CAL]);
      varactor_ref <= fast_lock_pkg::lo_nib(w[fast_lock_pkg::W_CAL]);
      force_tune <= {w[fast_lock_pkg::W_LVL][0], w[fast_lock_pkg::W_TUNE]};
      level_control_word <= fast_lock_pkg::bits_7_1(w[fast_lock_pkg::W_LVL]);
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  // A word committed to the active profile shows up in the addressed word
  AST_SLOT_SPLIT: assert property (
    (commit && (pif.act_prof == addr_r[6:4])) |=> (w[$past(addr_r[3:0])] == $past(data_r)))
    else $error("Commit slot does not follow the address byte");

  AST_COMMIT_STORES: assert property (
    commit |=> (pif.rd_data == $past(data_r)))
    else $error("Committed word not found in the store");

  AST_READBACK: assert property (
    (setup_ph && sel_read && !addr_r[7]) |=> (prdata[7:0] == $past(pif.rd_data)) && pready)
    else $error("Readback does not show the stored word");

  AST_NEED_CLOCK_EN: assert property (
    (wr_acc && sel_ctrl && !pwdata[0]) |=> $stable(pif.rd_data) || $changed(addr_r))
    else $error("Word stored without the clock enable bit");

  AST_NO_COMMIT_OFF: assert property (
    commit |-> pwdata[1] && pwdata[0])
    else $error("Commit without both control bits");

  AST_PROFILE_SEL: assert property (
    (wr_acc && sel_setup) |=> (active_profile == $past(pwdata[7:5]))
    && (lock_enable == $past(pwdata[0])))
    else $error("Setup write did not select the profile");

  // Pin select flag follows the setup write
  AST_PIN_SELECT: assert property (
    (wr_acc && sel_setup) |=> (pin_select == $past(pwdata[1])))
    else $error("Setup write did not set the pin select flag");

  // Initial wide phase starts on every enabling setup write with a nonzero delay
  AST_WIDE_BW_START: assert property (
    sw_start |=> (wide_bw == ($past(delay_r) != 8'h00)))
    else $error("Wide-bandwidth phase did not start");

  AST_WORD5: assert property (
    lock_enable |=> (vco_bias_ref == $past(w[5][6:4])) && (varactor == $past(w[5][3:0])))
    else $error("Word 5 fields wrong");

  AST_WORD6: assert property (
    lock_enable |=> (bias_tcf == $past(w[6][7:6])) && (init_cp_current == $past(w[6][5:0])))
    else $error("Word 6 fields wrong");

  AST_WORD8_9: assert property (
    lock_enable |=> ({third_res, initial_third_resistor} == $past(w[8]))
    && ({third_cap, initial_third_capacitor} == $past(w[9])))
    else $error("Word 8 or 9 fields wrong");

  AST_WORD_A_B: assert property (
    lock_enable |=> ({first_cap, second_cap} == $past(w[10]))
    && ({first_res, initial_first_resistor} == $past(w[11])))
    else $error("Word A or B fields wrong");

  AST_WORD_C_D: assert property (
    lock_enable |=> ({varactor_ref_tcf, vco_divider} == $past({w[12][6:4], w[12][3:0]}))
    && ({vco_cal_offset, varactor_ref} == $past(w[13])))
    else $error("Word C or D fields wrong");

  AST_WORD_E_F: assert property (
    lock_enable |=> (force_tune == $past({w[15][0], w[14]}))
    && (level_control_word == $past(w[15][7:1])))
    else $error("Tune or level control fields wrong");

  AST_SYNTH_WORDS: assert property (
    lock_enable |=> (synth_frac[7:0] == $past(w[2])) && (synth_int[7:0] == $past(w[0])))
    else $error("Synthesizer words not least byte first");

  COV_COMMIT: cover property (commit ##[1:20] (setup_ph && sel_read));
  COV_SWITCH: cover property (sw_start ##1 wide_bw [*3]);
  COV_ERROR: cover property (pslverr);
  // Readback of a valid profile word
  COV_READBACK: cover property (setup_ph && sel_read && !addr_r[7]);

endmodule

// ---- apb_host.sv ----
`timescale 1ns/1ps
// ==========================================================
// APB host that programs the profile store
// ==========================================================
module apb_host (
  input  wire logic        sys_clk, // System clock
  output logic             psel,    // Select
  output logic             penable, // Access phase
  output logic             pwrite,  // Direction
  output logic      [11:0] paddr,   // Byte address
  output logic      [31:0] pwdata,  // Write data
  input  wire logic [31:0] prdata,  // Read data
  input  wire logic        pready,  // Ready
  input  wire logic        pslverr, // Error
  output logic             hung     // Wait ran out
);
  logic [31:0] rdata; // Data taken at the ready edge
  logic        err;   // Error taken at the ready edge
  initial {psel, penable, pwrite, paddr, pwdata, hung} = '0;
  // One transfer, held until pready is seen high at an edge
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge sys_clk);
      n++;
    end
    rdata = prdata;
    err = pslverr;
    hung <= (n >= 20);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
endmodule

// ---- synth_fast_lock_profile_store_tb.sv ----
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the profile store
// ==========================================================
module synth_fast_lock_profile_store_tb;
  logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, hung;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic lock_enable, pin_select, wide_bw;
  logic [2:0] active_profile, vco_bias_ref, varactor_ref_tcf;
  logic [10:0] synth_int;
  logic [22:0] synth_frac;
  logic [8:0] force_tune;
  logic [6:0] level_control_word;
  logic [1:0] bias_tcf;
  logic [5:0] init_cp_current, cp_current;
  logic [3:0] varactor, third_res, initial_third_resistor, third_cap, initial_third_capacitor;
  logic [3:0] first_cap, second_cap, first_res, initial_first_resistor, vco_divider, vco_cal_offset, varactor_ref;
  int miscompares = 0;
  int checks = 0;
  // Example words for profile three
  localparam logic [7:0] W [16] = '{8'h50, 8'h00, 8'h00, 8'h00, 8'h00, 8'h73, 8'hCA, 8'h12,
                                    8'h9F, 8'hF5, 8'h4D, 8'hD5, 8'h72, 8'hFC, 8'h62, 8'hC7};
  apb_host apb_host_inst (.sys_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
                          .pslverr, .hung);
  fast_lock_store fast_lock_store_inst (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .lock_enable, .pin_select, .active_profile, .wide_bw, .synth_int,
    .synth_frac, .vco_bias_ref, .varactor, .bias_tcf, .init_cp_current, .cp_current, .third_res,
    .initial_third_resistor, .third_cap, .initial_third_capacitor, .first_cap, .second_cap, .first_res,
    .initial_first_resistor, .varactor_ref_tcf, .vco_divider, .vco_cal_offset, .varactor_ref,
    .force_tune, .level_control_word);
  // Compare one value and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Store one word: address, data, then commit
  task automatic put(input logic [7:0] a, input logic [7:0] d, input logic [7:0] c);
    apb_host_inst.xfer(1'b1, fast_lock_pkg::ADR_ADDR, a);
    apb_host_inst.xfer(1'b1, fast_lock_pkg::ADR_DATA, d);
    apb_host_inst.xfer(1'b1, fast_lock_pkg::ADR_CTRL, c);
  endtask
  // Select a profile and let the fields settle
  task automatic sel(input logic [7:0] s);
    apb_host_inst.xfer(1'b1, fast_lock_pkg::ADR_SETUP, s);
    repeat (3) @(posedge sys_clk);
  endtask
  // Reset state of lock_enable and the control register
  task automatic t_reset;
    chk(lock_enable, 0);
    apb_host_inst.xfer(1'b0, fast_lock_pkg::ADR_CTRL, 8'h00);
    chk(apb_host_inst.rdata, 0);
  endtask
  // Program profile three and check every field
  task automatic t_program;
    sel(8'h60);
    for (int i = 0; i < 16; i++) put(8'h30 + i[7:0], W[i], 8'h03);
    sel(8'h61);
    chk(active_profile, 3);
    chk({synth_int[7:0], synth_frac[15:0]}, 24'h500000);
    chk(synth_int, 11'h050);
    chk(synth_frac, 0);
    chk({vco_bias_ref, varactor}, 7'h73);
    chk({bias_tcf, init_cp_current}, 8'hCA);
    chk(cp_current, 6'h12);
    chk({third_res, initial_third_resistor}, 8'h9F);
    chk({third_cap, initial_third_capacitor}, 8'hF5);
    chk({first_cap, second_cap}, 8'h4D);
    chk({first_res, initial_first_resistor}, 8'hD5);
    chk({varactor_ref_tcf, vco_divider}, 7'h72);
    chk({vco_cal_offset, varactor_ref}, 8'hFC);
    chk({level_control_word, force_tune}, 16'hC762);
  endtask
  // Read a stored word back, refuse bad accesses
  task automatic t_readback;
    apb_host_inst.xfer(1'b1, fast_lock_pkg::ADR_ADDR, 8'h3A);
    apb_host_inst.xfer(1'b0, fast_lock_pkg::ADR_READ, 8'h00);
    chk(apb_host_inst.rdata, 32'h0000004D);
    apb_host_inst.xfer(1'b1, 12'h000, 8'hFF);
    chk(apb_host_inst.err, 1);
    put(8'h05, 8'h11, 8'h02);
    apb_host_inst.xfer(1'b0, fast_lock_pkg::ADR_READ, 8'h00);
    chk(apb_host_inst.rdata, 0);
  endtask
  // Switch to profile zero after storing one word there
  task automatic t_switch;
    put(8'h05, 8'h11, 8'h03);
    apb_host_inst.xfer(1'b1, fast_lock_pkg::ADR_CTRL, 8'h00);
    apb_host_inst.xfer(1'b1, fast_lock_pkg::ADR_DELAY, 8'h14);
    sel(8'h03);
    chk({active_profile, vco_bias_ref, varactor}, 10'h011);
    chk(synth_int, 0);
    chk({pin_select, wide_bw}, 2'h3);
    repeat (20) @(posedge sys_clk);
    chk(wide_bw, 0);
  endtask
  // Verdict and end of run
  task automatic print_verdict;
    if (hung === 1'b1) miscompares++;
    if (miscompares == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge hung) print_verdict();
  initial
  begin
    rst_b = 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_program();
    t_readback();
    t_switch();
    print_verdict();
  end
endmodule
